// [sok_safety_override_ctrl.sv]
/*
 * sok_safety_override_ctrl: global and per-module safety override,
 * held-safe state, maintenance keyswitch power gating, downstream-safe
 * contact, interrupt status and a classic Wishbone register slave.
 * assumes app_cmd, app requests and comm_ok come from logic on clk_sys;
 * all contacts are asynchronous dry contacts, closed reads as 1.
 */
// Behaviour
// - override set forces outputs to safe values
// - override reset returns outputs to application
// - manual switch or configured application request sets
// - only reset contact clears, all sources inactive
// - logic module contacts act on every module
// - optional per-module contacts act locally only
// - both contacts jumpered pass automatically into run
// - maintenance keyswitch read on dedicated contact
// - workstation port powered only in adjust
// - tuning activity signalled to workstation, control room
// - downstream-safe contact read on designated input
// - held-safe request forces safe until human reset
// - lost communication forces that module safe
`timescale 1ns/1ps
module sok_safety_override_ctrl #(
    parameter int NUM_MOD = sok_pkg::SOK_NUM_MOD,
    parameter int OUT_W = sok_pkg::SOK_OUT_W,
    parameter int DEBOUNCE_CYC = sok_pkg::SOK_DEBOUNCE_CYC,
    parameter int JUMPER_CYC = sok_pkg::SOK_JUMPER_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // application logic
    input wire logic [NUM_MOD*OUT_W-1:0] app_cmd,
    input wire logic app_override_req,
    input wire logic app_hold_safe_req,
    input wire logic [NUM_MOD-1:0] comm_ok,
    // field contacts
    input wire logic override_set_input,
    input wire logic override_reset_input,
    input wire logic [NUM_MOD-1:0] mod_override_set_input,
    input wire logic [NUM_MOD-1:0] mod_override_reset_input,
    input wire logic tune_key_present,
    input wire logic tune_key_adjust,
    input wire logic downstream_safe_confirm,
    // outputs
    output logic [NUM_MOD*OUT_W-1:0] field_out,
    output logic maintenance_workstation_power_en,
    output logic tuning_to_maintenance_workstation,
    output logic tuning_to_control_room,
    output logic downstream_safe_ok,
    output logic override_active,
    output logic irq
);
    localparam int TOT = NUM_MOD * OUT_W;
    localparam int IRQ_W = sok_pkg::SOK_IRQ_W;
    localparam int NIN = sok_pkg::SOK_IX_MOD_LSB + 2 * NUM_MOD;
    localparam int JW = $clog2(JUMPER_CYC + 1);

    typedef struct packed {
        sok_pkg::sok_state_e st;
        logic [NUM_MOD-1:0] local_ovr;
        logic [TOT-1:0] field_out;
        logic app_set_cfg;
        logic [NUM_MOD-1:0] local_cfg;
        logic [TOT-1:0] safe_val;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic ack;
        logic [31:0] rdat;
        logic [JW-1:0] jump_cnt;
        logic jumper;
        logic power_en;
        logic confirm;
        logic [NUM_MOD-1:0] comm_q;
    } sok_core_s;

    sok_core_s cur;
    sok_core_s nx;

    logic [NIN-1:0] raw;
    logic [NIN-1:0] db;
    logic [NUM_MOD-1:0] lset;
    logic [NUM_MOD-1:0] lrst;
    logic bus_req;
    logic wr;
    logic [7:0] adr;
    logic set_src;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] ctrl_new;
    logic [31:0] safe_new;
    logic [31:0] en_new;
    logic [IRQ_W-1:0] clr;
    logic [IRQ_W-1:0] ev;
    logic [NUM_MOD-1:0] force_safe;

    // byte-lane merge for every writable register
    function automatic logic [31:0] sok_merge(input logic [31:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign raw = {mod_override_reset_input, mod_override_set_input,
                  downstream_safe_confirm, tune_key_adjust,
                  tune_key_present, override_reset_input,
                  override_set_input};

    generate
        for (genvar g = 0; g < NIN; g++) begin : g_deb
            sok_debounce #(
                .CYC(DEBOUNCE_CYC)
            ) u_deb (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .raw(raw[g]),
                .stable(db[g])
            );
        end
    endgenerate

    assign lset = db[sok_pkg::SOK_IX_MOD_LSB +: NUM_MOD];
    assign lrst = db[sok_pkg::SOK_IX_MOD_LSB + NUM_MOD +: NUM_MOD];

    assign bus_req = wb_cyc & wb_stb & ~cur.ack;
    assign wr = bus_req & wb_we;
    assign adr = {wb_adr[7:2], 2'b00};

    // jumpered set contact is no longer a live source
    assign set_src = (db[sok_pkg::SOK_IX_SET] & ~cur.jumper)
                   | (cur.app_set_cfg & app_override_req);

    assign ctrl_word = (32'(cur.app_set_cfg) << sok_pkg::SOK_CTRL_APP_SET)
                     | (32'(cur.local_cfg) << sok_pkg::SOK_CTRL_LOCAL_LSB);
    assign stat_word =
        (32'(cur.st != sok_pkg::SOK_RUN) << sok_pkg::SOK_ST_OVR)
      | (32'(cur.st == sok_pkg::SOK_HELD) << sok_pkg::SOK_ST_HELD_BIT)
      | (32'(cur.local_ovr) << sok_pkg::SOK_ST_LOCAL_LSB)
      | (32'(cur.power_en) << sok_pkg::SOK_ST_TUNING)
      | (32'(cur.confirm) << sok_pkg::SOK_ST_CONFIRM)
      | (32'(cur.jumper) << sok_pkg::SOK_ST_JUMPER)
      | (32'(NUM_MOD'(~cur.comm_q)) << sok_pkg::SOK_ST_COMM_LSB);

    assign ctrl_new = sok_merge(ctrl_word, wb_dat_w, wb_sel);
    assign safe_new = sok_merge(32'(cur.safe_val), wb_dat_w, wb_sel);
    assign en_new = sok_merge(32'(cur.irq_en), wb_dat_w, wb_sel);
    assign clr = (wr && adr == sok_pkg::SOK_ADR_IRQ_CLR)
               ? IRQ_W'(sok_merge(32'h0, wb_dat_w, wb_sel))
               : '0;

    always_comb begin
        nx = cur;
        ev = '0;
        force_safe = '0;

        // jumper detection: both contacts closed for the full hold
        if (db[sok_pkg::SOK_IX_SET] && db[sok_pkg::SOK_IX_RESET]) begin
            if (cur.jump_cnt == JW'(JUMPER_CYC)) begin
                nx.jumper = 1'b1;
            end else begin
                nx.jump_cnt = cur.jump_cnt + JW'(1);
            end
        end else begin
            nx.jump_cnt = '0;
            nx.jumper = 1'b0;
        end

        // global override; held request first, then set, then reset
        if (app_hold_safe_req) begin
            nx.st = sok_pkg::SOK_HELD;
        end else if (set_src) begin
            if (cur.st != sok_pkg::SOK_HELD) begin
                nx.st = sok_pkg::SOK_OVERRIDE;
            end
        end else if (db[sok_pkg::SOK_IX_RESET]) begin
            nx.st = sok_pkg::SOK_RUN;
        end

        // local overrides, only on modules configured for them
        for (int m = 0; m < NUM_MOD; m++) begin
            if (!cur.local_cfg[m]) begin
                nx.local_ovr[m] = 1'b0;
            end else if (lset[m]) begin
                nx.local_ovr[m] = 1'b1;
            end else if (lrst[m]) begin
                nx.local_ovr[m] = 1'b0;
            end
        end

        nx.power_en = db[sok_pkg::SOK_IX_TUNE_PRESENT]
                    & db[sok_pkg::SOK_IX_TUNE_ADJUST];
        nx.confirm = db[sok_pkg::SOK_IX_CONFIRM];
        nx.comm_q = comm_ok;

        // register slave: one wait state, unmapped reads give zero
        nx.ack = bus_req;
        nx.rdat = '0;
        if (bus_req && !wb_we) begin
            unique case (adr)
                sok_pkg::SOK_ADR_CTRL: nx.rdat = ctrl_word;
                sok_pkg::SOK_ADR_SAFE: nx.rdat = 32'(cur.safe_val);
                sok_pkg::SOK_ADR_STATUS: nx.rdat = stat_word;
                sok_pkg::SOK_ADR_IRQ_STAT: nx.rdat = 32'(cur.irq_stat);
                sok_pkg::SOK_ADR_IRQ_EN: nx.rdat = 32'(cur.irq_en);
                default: nx.rdat = '0;
            endcase
        end
        if (wr && adr == sok_pkg::SOK_ADR_CTRL) begin
            nx.app_set_cfg = ctrl_new[sok_pkg::SOK_CTRL_APP_SET];
            nx.local_cfg = ctrl_new[sok_pkg::SOK_CTRL_LOCAL_LSB +: NUM_MOD];
        end
        if (wr && adr == sok_pkg::SOK_ADR_SAFE) begin
            nx.safe_val = safe_new[TOT-1:0];
        end
        if (wr && adr == sok_pkg::SOK_ADR_IRQ_EN) begin
            nx.irq_en = en_new[IRQ_W-1:0];
        end

        // outputs follow the state taken at this same edge
        for (int m = 0; m < NUM_MOD; m++) begin
            force_safe[m] = (nx.st != sok_pkg::SOK_RUN)
                          | nx.local_ovr[m]
                          | ~comm_ok[m];
            nx.field_out[m*OUT_W +: OUT_W] = force_safe[m]
                ? nx.safe_val[m*OUT_W +: OUT_W]
                : app_cmd[m*OUT_W +: OUT_W];
        end

        ev[sok_pkg::SOK_IRQ_OVR_SET] = (cur.st == sok_pkg::SOK_RUN)
                                     & (nx.st != sok_pkg::SOK_RUN);
        ev[sok_pkg::SOK_IRQ_OVR_CLR] = (cur.st != sok_pkg::SOK_RUN)
                                     & (nx.st == sok_pkg::SOK_RUN);
        ev[sok_pkg::SOK_IRQ_HELD] = (cur.st != sok_pkg::SOK_HELD)
                                  & (nx.st == sok_pkg::SOK_HELD);
        ev[sok_pkg::SOK_IRQ_TUNE] = nx.power_en & ~cur.power_en;
        ev[sok_pkg::SOK_IRQ_COMM] = |(cur.comm_q & ~comm_ok);
        ev[sok_pkg::SOK_IRQ_CONFIRM] = nx.confirm ^ cur.confirm;
        // a new event outranks a clear in the same cycle
        nx.irq_stat = (cur.irq_stat & ~clr) | ev;
    end

    // power-up lands in held-safe: outputs safe until a reset action
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
            cur.st <= sok_pkg::SOK_HELD;
            cur.app_set_cfg <=
                sok_pkg::SOK_CTRL_RST[sok_pkg::SOK_CTRL_APP_SET];
            cur.local_cfg <=
                sok_pkg::SOK_CTRL_RST[sok_pkg::SOK_CTRL_LOCAL_LSB +: NUM_MOD];
            cur.safe_val <= sok_pkg::SOK_SAFE_RST[TOT-1:0];
            cur.irq_en <= sok_pkg::SOK_IRQ_EN_RST[IRQ_W-1:0];
            cur.comm_q <= '1;
        end else begin
            cur <= nx;
        end
    end

    assign wb_dat_r = cur.rdat;
    assign wb_ack = cur.ack;
    assign field_out = cur.field_out;
    assign maintenance_workstation_power_en = cur.power_en;
    assign tuning_to_maintenance_workstation = cur.power_en;
    assign tuning_to_control_room = cur.power_en;
    assign downstream_safe_ok = cur.confirm;
    assign override_active = cur.st != sok_pkg::SOK_RUN;
    assign irq = |(cur.irq_stat & cur.irq_en);

    property p_global_safe;
        @(posedge clk_sys) disable iff (!nrst)
        cur.st != sok_pkg::SOK_RUN |-> field_out == cur.safe_val;
    endproperty
    a_global_safe: assert property (p_global_safe)
        else $error("override set but outputs not safe");

    property p_normal;
        @(posedge clk_sys) disable iff (!nrst)
        (cur.st == sok_pkg::SOK_RUN && cur.local_ovr == '0
            && $past(comm_ok) == '1) |-> field_out == $past(app_cmd);
    endproperty
    a_normal: assert property (p_normal)
        else $error("outputs not under application control");

    property p_app_set;
        @(posedge clk_sys) disable iff (!nrst)
        (cur.app_set_cfg && app_override_req) |=> override_active;
    endproperty
    a_app_set: assert property (p_app_set)
        else $error("application request did not set override");

    property p_reset_cause;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(cur.st == sok_pkg::SOK_RUN) |->
            $past(db[sok_pkg::SOK_IX_RESET]) && !$past(set_src)
            && !$past(app_hold_safe_req);
    endproperty
    a_reset_cause: assert property (p_reset_cause)
        else $error("override cleared without a valid reset");

    property p_local;
        @(posedge clk_sys) disable iff (!nrst)
        (cur.local_ovr[0] && !cur.local_ovr[NUM_MOD-1]
            && cur.st == sok_pkg::SOK_RUN && $past(comm_ok) == '1) |->
            field_out[OUT_W-1:0] == cur.safe_val[OUT_W-1:0]
            && field_out[TOT-1 -: OUT_W] == $past(app_cmd[TOT-1 -: OUT_W]);
    endproperty
    a_local: assert property (p_local)
        else $error("local override leaked or missed");

    property p_jumper;
        @(posedge clk_sys) disable iff (!nrst)
        (cur.jumper && db[sok_pkg::SOK_IX_RESET] && !app_hold_safe_req
            && !(cur.app_set_cfg && app_override_req)) |=>
            cur.st == sok_pkg::SOK_RUN;
    endproperty
    a_jumper: assert property (p_jumper)
        else $error("jumpered contacts did not reach run");

    property p_power;
        @(posedge clk_sys) disable iff (!nrst)
        ##1 maintenance_workstation_power_en ==
            ($past(db[sok_pkg::SOK_IX_TUNE_PRESENT])
             && $past(db[sok_pkg::SOK_IX_TUNE_ADJUST]));
    endproperty
    a_power: assert property (p_power)
        else $error("workstation port power wrong");

    property p_tune_flag;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(maintenance_workstation_power_en) |->
            tuning_to_control_room && tuning_to_maintenance_workstation
            && cur.irq_stat[sok_pkg::SOK_IRQ_TUNE];
    endproperty
    a_tune_flag: assert property (p_tune_flag)
        else $error("tuning activity not signalled");

    property p_held;
        @(posedge clk_sys) disable iff (!nrst)
        app_hold_safe_req |=> cur.st == sok_pkg::SOK_HELD
            ##1 (cur.st == sok_pkg::SOK_HELD
                 || $past(db[sok_pkg::SOK_IX_RESET]));
    endproperty
    a_held: assert property (p_held)
        else $error("held-safe entered or left wrongly");

    property p_comm;
        @(posedge clk_sys) disable iff (!nrst)
        !comm_ok[0] |=> field_out[OUT_W-1:0] == cur.safe_val[OUT_W-1:0];
    endproperty
    a_comm: assert property (p_comm)
        else $error("lost link did not force module safe");

    property p_set_wins;
        @(posedge clk_sys) disable iff (!nrst)
        (set_src && db[sok_pkg::SOK_IX_RESET]) |=> override_active;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("reset beat set");
endmodule

// [sok_pkg.sv]
/*
 * sok_pkg: constants and types shared by the safety override and
 * keyswitch controller and its self-checking bench.
 * assumes a 40 MHz clk_sys and a 32-bit classic Wishbone register bus.
 */
package sok_pkg;

    // geometry
    localparam int SOK_NUM_MOD = 4;
    localparam int SOK_OUT_W = 8;
    localparam int SOK_IRQ_W = 6;

    // timing
    localparam longint SOK_CLK_HZ = 40_000_000;
    localparam longint SOK_DEBOUNCE_US = 1000;
    localparam longint SOK_JUMPER_MS = 100;
    localparam int SOK_DEBOUNCE_CYC =
        int'((SOK_DEBOUNCE_US * SOK_CLK_HZ + 999_999) / 1_000_000);
    localparam int SOK_JUMPER_CYC =
        int'((SOK_JUMPER_MS * SOK_CLK_HZ + 999) / 1000);

    // register byte offsets
    localparam logic [7:0] SOK_ADR_CTRL = 8'h00;
    localparam logic [7:0] SOK_ADR_SAFE = 8'h04;
    localparam logic [7:0] SOK_ADR_STATUS = 8'h08;
    localparam logic [7:0] SOK_ADR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] SOK_ADR_IRQ_CLR = 8'h10;
    localparam logic [7:0] SOK_ADR_IRQ_EN = 8'h14;

    // reset values
    localparam logic [31:0] SOK_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SOK_SAFE_RST = 32'h0000_0000;
    localparam logic [31:0] SOK_IRQ_EN_RST = 32'h0000_0000;

    // field positions
    localparam int SOK_CTRL_APP_SET = 0;
    localparam int SOK_CTRL_LOCAL_LSB = 4;
    localparam int SOK_ST_OVR = 0;
    localparam int SOK_ST_HELD_BIT = 1;
    localparam int SOK_ST_LOCAL_LSB = 4;
    localparam int SOK_ST_TUNING = 8;
    localparam int SOK_ST_CONFIRM = 9;
    localparam int SOK_ST_JUMPER = 10;
    localparam int SOK_ST_COMM_LSB = 12;
    localparam int SOK_IRQ_OVR_SET = 0;
    localparam int SOK_IRQ_OVR_CLR = 1;
    localparam int SOK_IRQ_HELD = 2;
    localparam int SOK_IRQ_TUNE = 3;
    localparam int SOK_IRQ_COMM = 4;
    localparam int SOK_IRQ_CONFIRM = 5;

    // debounced contact indices
    localparam int SOK_IX_SET = 0;
    localparam int SOK_IX_RESET = 1;
    localparam int SOK_IX_TUNE_PRESENT = 2;
    localparam int SOK_IX_TUNE_ADJUST = 3;
    localparam int SOK_IX_CONFIRM = 4;
    localparam int SOK_IX_MOD_LSB = 5;

    typedef enum logic [2:0] {
        SOK_HELD = 3'b001,
        SOK_OVERRIDE = 3'b010,
        SOK_RUN = 3'b100
    } sok_state_e;

endpackage

// [sok_debounce.sv]
/*
 * sok_debounce: two-flop synchroniser and stability filter for one
 * dry contact. assumes the raw input is asynchronous to clk_sys;
 * the filtered level reads open (0) from reset until proven closed.
 */
`timescale 1ns/1ps
module sok_debounce #(
    parameter int CYC = 40000
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // contact
    input wire logic raw,
    output logic stable
);
    localparam int CW = $clog2(CYC + 1);

    typedef struct packed {
        logic s1;
        logic s2;
        logic level;
        logic [CW-1:0] cnt;
    } sok_deb_s;

    sok_deb_s cur;
    sok_deb_s nx;

    always_comb begin
        nx = cur;
        nx.s1 = raw;
        nx.s2 = cur.s1;
        if (cur.s2 == cur.level) begin
            nx.cnt = '0;
        end else if (cur.cnt == CW'(CYC - 1)) begin
            nx.level = cur.s2;
            nx.cnt = '0;
        end else begin
            nx.cnt = cur.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
        end else begin
            cur <= nx;
        end
    end

    assign stable = cur.level;
endmodule

// [sok_field_contacts.sv]
/*
 * sok_field_contacts: behavioural model of the keyswitches, pushbuttons
 * and jumpers wired to the controller. assumes the bench sets the wanted
 * contact levels in cmd; closed reads as 1.
 */
`timescale 1ns/1ps
module sok_field_contacts (
    // clock
    input wire logic clk_sys,
    // wanted levels
    input wire logic [11:0] cmd,
    input wire logic secured,
    // contacts
    output logic [11:0] contact,
    output logic confirm
);
    logic [11:0] tgt = 12'h000;
    logic [11:0] old = 12'h000;
    logic [2:0] cnt = 3'h0;

    // real contacts chatter for a few cycles on every change
    always @(posedge clk_sys) begin
        if (cmd != tgt) begin
            old <= tgt;
            tgt <= cmd;
            cnt <= 3'h4;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
        end
    end
    assign contact = (cnt != 3'h0 && cnt[0]) ? old : tgt;
    // closed only while downstream equipment is secured
    assign confirm = secured;
endmodule

// [tb.sv]
/*
 * tb: self-checking bench for the safety override controller.
 * assumes shortened debounce and jumper counts; the contact model
 * supplies every field contact.
 */
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] SAFEV = 32'ha5c3_5a3c;
    logic clk_sys, nrst, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel, comm_ok;
    logic [31:0] wb_dat_w, wb_dat_r, app_cmd, field_out, rd;
    logic app_override_req, app_hold_safe_req, secured, confirm;
    logic [11:0] cmd, cont;
    logic pwr, tune_ws, tune_cr, ds_ok, ovr, irq;
    int failures = 0, compares = 0, cycles = 0;

    sok_field_contacts i_contacts (.clk_sys(clk_sys), .cmd(cmd),
        .secured(secured), .contact(cont), .confirm(confirm));

    sok_safety_override_ctrl #(.DEBOUNCE_CYC(4), .JUMPER_CYC(20)) i_dut (
        .clk_sys(clk_sys), .nrst(nrst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .app_cmd(app_cmd), .app_override_req(app_override_req),
        .app_hold_safe_req(app_hold_safe_req), .comm_ok(comm_ok),
        .override_set_input(cont[0]), .override_reset_input(cont[1]),
        .mod_override_set_input(cont[5:2]),
        .mod_override_reset_input(cont[9:6]),
        .tune_key_present(cont[10]), .tune_key_adjust(cont[11]),
        .downstream_safe_confirm(confirm), .field_out(field_out),
        .maintenance_workstation_power_en(pwr),
        .tuning_to_maintenance_workstation(tune_ws),
        .tuning_to_control_room(tune_cr), .downstream_safe_ok(ds_ok),
        .override_active(ovr), .irq(irq));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic close_out;
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // generous ceiling: the whole sequence needs about 600 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            close_out();
        end
    end

    task automatic check_word(input logic [31:0] got, exp, input string s);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, s, got,
                exp);
        end
    endtask

    task automatic check_bit(input logic got, exp, input string s);
        check_word({31'h0, got}, {31'h0, exp}, s);
    endtask

    function automatic logic [31:0] fld(input logic [3:0] safe_m);
        logic [31:0] r;
        for (int m = 0; m < 4; m++) begin
            r[m*8 +: 8] = safe_m[m] ? SAFEV[m*8 +: 8] : app_cmd[m*8 +: 8];
        end
        return r;
    endfunction

    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one classic cycle; read data lands in rd
    task automatic wb_xfer(input logic we, input logic [7:0] a,
                           input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat_w <= d;
        // ack taken as sampled at a rising edge; only the timeout ends a hang
        do begin
            @(posedge clk_sys);
        end while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e);
        wb_xfer(1'b0, a, 32'h0);
        check_word(rd & m, e, "register");
    endtask

    task automatic set_cmd(input logic [11:0] v);
        @(posedge clk_sys);
        cmd <= v;
        settle(20);
    endtask

    // momentary press of the given contacts
    task automatic press(input logic [11:0] bits);
        set_cmd(cmd | bits);
        set_cmd(cmd & ~bits);
    endtask

    task automatic state_chk(input logic e, input logic [3:0] m);
        check_bit(ovr, e, "override");
        check_word(field_out, fld(m), "field");
    endtask

    initial begin
        {wb_cyc, wb_stb, wb_we, app_override_req, app_hold_safe_req} = '0;
        {wb_adr, wb_sel, wb_dat_w, cmd, secured} = '0;
        comm_ok = 4'hf;
        app_cmd = 32'h1234_5678;
        nrst = 1'b0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        settle(2);
        check_bit(ovr, 1'b1, "power-up");
        check_word(field_out, 32'h0, "reset field");
        rd_chk(sok_pkg::SOK_ADR_CTRL, '1, sok_pkg::SOK_CTRL_RST);
        rd_chk(sok_pkg::SOK_ADR_SAFE, '1, sok_pkg::SOK_SAFE_RST);
        rd_chk(sok_pkg::SOK_ADR_IRQ_EN, '1, sok_pkg::SOK_IRQ_EN_RST);
        rd_chk(8'h1c, '1, 32'h0);
        wb_xfer(1'b1, sok_pkg::SOK_ADR_SAFE, SAFEV);
        rd_chk(sok_pkg::SOK_ADR_SAFE, '1, SAFEV);
        state_chk(1'b1, 4'hf);
        press(12'h002);
        state_chk(1'b0, 4'h0);
        rd_chk(sok_pkg::SOK_ADR_IRQ_STAT, 32'h2, 32'h2);
        check_bit(irq, 1'b0, "masked irq");
        wb_xfer(1'b1, sok_pkg::SOK_ADR_IRQ_EN, 32'h2);
        settle(2);
        check_bit(irq, 1'b1, "irq raised");
        wb_xfer(1'b1, sok_pkg::SOK_ADR_IRQ_CLR, 32'h2);
        settle(2);
        check_bit(irq, 1'b0, "irq cleared");
        // application source ignored until configured
        @(posedge clk_sys);
        app_override_req <= 1'b1;
        settle(3);
        state_chk(1'b0, 4'h0);
        wb_xfer(1'b1, sok_pkg::SOK_ADR_CTRL, 32'h1);
        settle(2);
        state_chk(1'b1, 4'hf);
        press(12'h002);
        state_chk(1'b1, 4'hf);
        @(posedge clk_sys);
        app_override_req <= 1'b0;
        settle(3);
        state_chk(1'b1, 4'hf);
        press(12'h002);
        state_chk(1'b0, 4'h0);
        set_cmd(12'h003);
        state_chk(1'b1, 4'hf);
        set_cmd(12'h002);
        state_chk(1'b0, 4'h0);
        set_cmd(12'h000);
        // jumpered contacts
        @(posedge clk_sys);
        cmd <= 12'h003;
        settle(60);
        state_chk(1'b0, 4'h0);
        rd_chk(sok_pkg::SOK_ADR_STATUS, 32'h400, 32'h400);
        set_cmd(12'h000);
        // local contacts, module 0 enabled only
        wb_xfer(1'b1, sok_pkg::SOK_ADR_CTRL, 32'h10);
        set_cmd(12'h00c);
        state_chk(1'b0, 4'h1);
        set_cmd(12'h040);
        state_chk(1'b0, 4'h0);
        set_cmd(12'h000);
        @(posedge clk_sys);
        comm_ok <= 4'ha;
        settle(2);
        state_chk(1'b0, 4'h5);
        @(posedge clk_sys);
        comm_ok <= 4'hf;
        settle(2);
        state_chk(1'b0, 4'h0);
        @(posedge clk_sys);
        app_hold_safe_req <= 1'b1;
        @(posedge clk_sys);
        app_hold_safe_req <= 1'b0;
        settle(3);
        state_chk(1'b1, 4'hf);
        rd_chk(sok_pkg::SOK_ADR_STATUS, 32'h3, 32'h3);
        press(12'h002);
        state_chk(1'b0, 4'h0);
        for (int k = 0; k < 4; k++) begin
            set_cmd({k[1:0], 10'h0});
            check_bit(pwr, k == 3, "port power");
            check_bit(tune_ws, k == 3, "tuning to station");
            check_bit(tune_cr, k == 3, "tuning to room");
        end
        set_cmd(12'h000);
        @(posedge clk_sys);
        secured <= 1'b1;
        settle(20);
        check_bit(ds_ok, 1'b1, "confirm closed");
        @(posedge clk_sys);
        secured <= 1'b0;
        settle(20);
        check_bit(ds_ok, 1'b0, "confirm open");
        close_out();
    end
endmodule
